// file: rtl/asi_pkg.sv
// Constants and types shared by the audio serial interface setup logic.
package asi_pkg;

    localparam logic [7:0]  ASI_SETUP_ADR   = 8'h0c;
    localparam logic [7:0]  ASI_TXWORD_ADR  = 8'h20;
    localparam logic [7:0]  ASI_RXWORD_ADR  = 8'h24;
    localparam logic [7:0]  ASI_STATUS_ADR  = 8'h28;

    localparam logic [31:0] ASI_SETUP_RST   = 32'h8080_0000;
    localparam logic [31:0] ASI_WRITABLE    = 32'hffff_ff01;

    localparam int          ASI_TXW_HI      = 31;
    localparam int          ASI_TXW_LO      = 30;
    localparam int          ASI_RXLEN_HI    = 29;
    localparam int          ASI_RXLEN_LO    = 24;
    localparam int          ASI_RXW_HI      = 23;
    localparam int          ASI_RXW_LO      = 22;
    localparam int          ASI_TXLEN_HI    = 21;
    localparam int          ASI_TXLEN_LO    = 16;
    localparam int          ASI_RXSTEREO    = 15;
    localparam int          ASI_LOOP        = 14;
    localparam int          ASI_COMMON_FS   = 13;
    localparam int          ASI_RXCLK_OWN   = 12;
    localparam int          ASI_TXFS_INV    = 11;
    localparam int          ASI_RXFS_INV    = 10;
    localparam int          ASI_TXEDGE_FALL = 9;
    localparam int          ASI_RXEDGE_FALL = 8;
    localparam int          ASI_MODE        = 0;

    localparam int          ASI_ST_VALID    = 0;
    localparam int          ASI_ST_CHAN     = 1;

    localparam logic [5:0]  ASI_MAX_I2S     = 6'h20;
    localparam logic [5:0]  ASI_MAX_AC97    = 6'h14;

    typedef enum logic [1:0] {
        ASI_W8  = 2'h0,
        ASI_W16 = 2'h1,
        ASI_W32 = 2'h2,
        ASI_W64 = 2'h3
    } asi_width_type;

    typedef enum logic [1:0] {
        ASI_IDLE  = 2'b01,
        ASI_SHIFT = 2'b10
    } asi_ser_type;

endpackage : asi_pkg

// file: rtl/asi_setup.sv
// Audio serial interface setup register, its bus slave and the serial link side.
// What this block does
// R1: Transmit buffer write width from two-bit code.
// R2: Software flushes buffer before changing width.
// R3: Receive read width field, resets to 32.
// R4: Receive bits per channel, capped 32/20.
// R5: Transmit bits per channel, capped 32/20.
// R6: Receive stereo select, effective only in I2S.
// R7: Stereo frame halves carry left then right.
// R8: Loopback feeds transmit data into receive.
// R9: Shared sync makes receive use transmit sync.
// R10: Shared sync needs shared bit clocks too; not enforced, receive follows its own clock select.
// R11: Receive bit clock shared or own.
// R12: Transmit frame sync polarity select.
// R13: Receive frame sync polarity select.
// R14: Transmit changes on chosen bit clock edge.
// R15: Receive samples on chosen bit clock edge.
// R16: Mode bit selects I2S or AC97.
// R17: Setup register resets to documented value, stays RW except bits 7:1, which are not writable and read as zero.
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps

module asi_link
    import asi_pkg::*;
(
    input  wire logic        lclk_i,
    input  wire logic        rst_i,
    input  wire logic [31:0] cfg_i,
    input  wire logic [31:0] txw_i,
    input  wire logic        req_i,
    input  wire logic        tx_bclk_i,
    input  wire logic        rx_bclk_i,
    input  wire logic        tx_fs_i,
    input  wire logic        rx_fs_i,
    input  wire logic        rx_data_i,
    output logic             ack_o,
    output logic [31:0]      rxw_o,
    output logic             rxtog_o,
    output logic             rxch_o,
    output logic             tx_data_o
);

    typedef struct packed {
        logic        rs1, rs2, q1, q2, seen;
        logic [31:0] cfg, txw;
        logic        tb1, tb2, tb3, rb1, rb2, rb3;
        logic        tf1, tf2, rf1, rf2, rd1, rd2;
        logic        tfs_prev, rfs_prev;
        asi_ser_type tst;
        logic [5:0]  tidx;
        logic [31:0] tword;
        logic        tdo;
        asi_ser_type rst;
        logic [5:0]  rcnt;
        logic [31:0] rsh, rword;
        logic        rtog, rch, rchan;
    } asi_link_type;

    asi_link_type s, n;
    logic [5:0]   maxl, txlen, rxlen;
    logic         tx_act, rx_act, tfs, rfs, rdin, stereo, rx_start;

    always_comb
    begin
        n = s;
        n.rs1 = rst_i;
        n.rs2 = s.rs1;
        n.q1 = req_i;
        n.q2 = s.q1;
        n.tb1 = tx_bclk_i;
        n.tb2 = s.tb1;
        n.tb3 = s.tb2;
        n.rb1 = rx_bclk_i;
        n.rb2 = s.rb1;
        n.rb3 = s.rb2;
        n.tf1 = tx_fs_i;
        n.tf2 = s.tf1;
        n.rf1 = rx_fs_i;
        n.rf2 = s.rf1;
        n.rd1 = rx_data_i;
        n.rd2 = s.rd1;
        maxl = s.cfg[ASI_MODE] ? ASI_MAX_AC97 : ASI_MAX_I2S; // R16
        txlen = (s.cfg[ASI_TXLEN_HI:ASI_TXLEN_LO] > maxl) ? maxl : s.cfg[ASI_TXLEN_HI:ASI_TXLEN_LO]; // R5
        rxlen = (s.cfg[ASI_RXLEN_HI:ASI_RXLEN_LO] > maxl) ? maxl : s.cfg[ASI_RXLEN_HI:ASI_RXLEN_LO]; // R4
        tx_act = s.cfg[ASI_TXEDGE_FALL] ? (~s.tb2 & s.tb3) : (s.tb2 & ~s.tb3); // R14
        if (s.cfg[ASI_RXCLK_OWN]) // R11
        begin
            rx_act = s.cfg[ASI_RXEDGE_FALL] ? (~s.rb2 & s.rb3) : (s.rb2 & ~s.rb3); // R15
        end
        else
        begin
            rx_act = s.cfg[ASI_RXEDGE_FALL] ? (~s.tb2 & s.tb3) : (s.tb2 & ~s.tb3); // R15
        end
        tfs = s.tf2 ^ s.cfg[ASI_TXFS_INV]; // R12
        rfs = s.cfg[ASI_COMMON_FS] ? tfs : (s.rf2 ^ s.cfg[ASI_RXFS_INV]); // R9 R13
        rdin = s.cfg[ASI_LOOP] ? s.tdo : s.rd2; // R8
        stereo = s.cfg[ASI_RXSTEREO] & ~s.cfg[ASI_MODE]; // R6
        rx_start = stereo ? (rfs != s.rfs_prev) : (rfs & ~s.rfs_prev); // R7
        if (s.q2 != s.seen)
        begin
            n.seen = s.q2;
            n.cfg = cfg_i;
            n.txw = txw_i;
        end
        if (tx_act)
        begin
            n.tfs_prev = tfs;
            if (tfs && !s.tfs_prev && txlen != 6'h0)
            begin
                n.tst = ASI_SHIFT;
                n.tword = s.txw;
                n.tidx = 6'(txlen - 6'h1);
                n.tdo = s.txw[5'(txlen - 6'h1)]; // R14
            end
            else if (s.tst == ASI_SHIFT)
            begin
                if (s.tidx == 6'h0)
                begin
                    n.tst = ASI_IDLE;
                    n.tdo = 1'b0;
                end
                else
                begin
                    n.tidx = 6'(s.tidx - 6'h1);
                    n.tdo = s.tword[5'(s.tidx - 6'h1)];
                end
            end
        end
        if (rx_act)
        begin
            n.rfs_prev = rfs;
            if (rx_start && rxlen != 6'h0)
            begin
                n.rst = ASI_SHIFT;
                n.rsh = {31'h0, rdin}; // R15
                n.rcnt = 6'h1;
                n.rchan = stereo & ~rfs; // R7
            end
            else if (s.rst == ASI_SHIFT)
            begin
                n.rsh = {s.rsh[30:0], rdin}; // R15
                n.rcnt = 6'(s.rcnt + 6'h1);
            end
            if (n.rst == ASI_SHIFT && n.rcnt >= rxlen)
            begin
                n.rst = ASI_IDLE;
                n.rword = n.rsh;
                n.rtog = ~s.rtog;
                n.rch = n.rchan;
                n.rcnt = 6'h0;
            end
        end
        if (s.rs2)
        begin
            n = '0;
            n.rs1 = rst_i;
            n.rs2 = s.rs1;
            n.cfg = ASI_SETUP_RST;
            n.tst = ASI_IDLE;
            n.rst = ASI_IDLE;
        end
    end

    always_ff @(posedge lclk_i)
    begin
        s <= n;
    end

    assign ack_o     = s.seen;
    assign rxw_o     = s.rword;
    assign rxtog_o   = s.rtog;
    assign rxch_o    = s.rch;
    assign tx_data_o = s.tdo;

    sequence tx_frame_start;
        tx_act && tfs && !s.tfs_prev && txlen != 6'h0;
    endsequence

    chk_tx_msb_first: assert property (@(posedge lclk_i) disable iff (s.rs2) // R14
        tx_frame_start |=> (s.tdo == $past(s.txw[5'(txlen - 6'h1)])))
        else $error("First transmit bit is not the top bit of the sample.");

    chk_tx_edge_only: assert property (@(posedge lclk_i) disable iff (s.rs2) // R14
        (s.tst == ASI_SHIFT && $changed(s.tdo)) |-> $past(tx_act))
        else $error("Transmit data changed away from the selected clock edge.");

    chk_rx_len_cap: assert property (@(posedge lclk_i) disable iff (s.rs2) // R4
        s.rcnt <= (s.cfg[ASI_MODE] ? ASI_MAX_AC97 : ASI_MAX_I2S))
        else $error("Receive bit count passed the mode limit.");

    chk_rx_edge_only: assert property (@(posedge lclk_i) disable iff (s.rs2) // R15
        $changed(s.rsh) |-> $past(rx_act))
        else $error("Receive data sampled away from the selected clock edge.");

    chk_loop_path: assert property (@(posedge lclk_i) disable iff (s.rs2) // R8
        (rx_act && s.rst == ASI_SHIFT && !rx_start && s.cfg[ASI_LOOP]) |=> (s.rsh[0] == $past(s.tdo)))
        else $error("Loopback did not feed transmit data to receive.");

    chk_mono_chan: assert property (@(posedge lclk_i) disable iff (s.rs2) // R6
        (rx_act && rx_start && !stereo && rxlen != 6'h0) |=> !s.rchan)
        else $error("Mono framing marked a second channel.");

endmodule : asi_link

module asi_setup
    import asi_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic [1:0]       tx_width_o,
    output logic [1:0]       rx_width_o,
    output logic [5:0]       tx_bits_o,
    output logic [5:0]       rx_bits_o,
    output logic             mode_ac97_o,
    input  wire logic        lclk_i,
    input  wire logic        tx_bclk_i,
    input  wire logic        rx_bclk_i,
    input  wire logic        tx_fs_i,
    input  wire logic        rx_fs_i,
    input  wire logic        rx_data_i,
    output logic             tx_data_o
);

    typedef struct packed {
        logic [31:0] cfg, txw, shcfg, shtx;
        logic        req, as1, as2;
        logic        ts1, ts2, ts3;
        logic [31:0] rxd;
        logic        valid, rch, ack;
        logic [31:0] dat;
    } asi_bus_type;

    asi_bus_type s, n;
    logic        hit, link_ack, link_tog, link_ch;
    logic [31:0] link_word;

    asi_link u_link (
        .lclk_i    (lclk_i),
        .rst_i     (rst_i),
        .cfg_i     (s.shcfg),
        .txw_i     (s.shtx),
        .req_i     (s.req),
        .tx_bclk_i (tx_bclk_i),
        .rx_bclk_i (rx_bclk_i),
        .tx_fs_i   (tx_fs_i),
        .rx_fs_i   (rx_fs_i),
        .rx_data_i (rx_data_i),
        .ack_o     (link_ack),
        .rxw_o     (link_word),
        .rxtog_o   (link_tog),
        .rxch_o    (link_ch),
        .tx_data_o (tx_data_o)
    );

    always_comb
    begin
        n = s;
        n.ack = 1'b0;
        n.dat = 32'h0;
        n.as1 = link_ack;
        n.as2 = s.as1;
        n.ts1 = link_tog;
        n.ts2 = s.ts1;
        n.ts3 = s.ts2;
        hit = wb_cyc_i & wb_stb_i & ~s.ack;
        if (s.as2 == s.req && (s.shcfg != s.cfg || s.shtx != s.txw))
        begin
            n.shcfg = s.cfg;
            n.shtx = s.txw;
            n.req = ~s.req;
        end
        if (hit)
        begin
            n.ack = 1'b1;
            unique case (wb_adr_i)
                ASI_SETUP_ADR:
                begin
                    n.dat = s.cfg; // R17
                    for (int b = 0; b < 4; b++)
                    begin
                        if (wb_we_i && wb_sel_i[b])
                        begin
                            n.cfg[8*b +: 8] = wb_dat_i[8*b +: 8] & ASI_WRITABLE[8*b +: 8]; // R1 R3 R17
                        end
                    end
                end
                ASI_TXWORD_ADR:
                begin
                    n.dat = s.txw;
                    for (int b = 0; b < 4; b++)
                    begin
                        if (wb_we_i && wb_sel_i[b])
                        begin
                            n.txw[8*b +: 8] = wb_dat_i[8*b +: 8];
                        end
                    end
                end
                ASI_RXWORD_ADR:
                begin
                    n.dat = s.rxd;
                    if (!wb_we_i)
                    begin
                        n.valid = 1'b0;
                    end
                end
                ASI_STATUS_ADR:
                begin
                    n.dat[ASI_ST_VALID] = s.valid;
                    n.dat[ASI_ST_CHAN] = s.rch;
                end
                default:
                begin
                    n.dat = 32'h0;
                end
            endcase
        end
        if (s.ts2 != s.ts3)
        begin
            n.rxd = link_word;
            n.rch = link_ch;
            n.valid = 1'b1;
        end
        if (rst_i)
        begin
            n = '0;
            n.cfg = ASI_SETUP_RST; // R17
            n.shcfg = ASI_SETUP_RST;
        end
    end

    always_ff @(posedge clk_i)
    begin
        s <= n;
    end

    assign wb_dat_o    = s.dat;
    assign wb_ack_o    = s.ack;
    assign tx_width_o  = s.cfg[ASI_TXW_HI:ASI_TXW_LO]; // R1
    assign rx_width_o  = s.cfg[ASI_RXW_HI:ASI_RXW_LO]; // R3
    assign tx_bits_o   = s.cfg[ASI_TXLEN_HI:ASI_TXLEN_LO]; // R5
    assign rx_bits_o   = s.cfg[ASI_RXLEN_HI:ASI_RXLEN_LO]; // R4
    assign mode_ac97_o = s.cfg[ASI_MODE]; // R16

    chk_reset_widths: assert property (@(posedge clk_i) // R3
        rst_i |=> (tx_width_o == ASI_W32 && rx_width_o == ASI_W32 && !mode_ac97_o))
        else $error("Setup register did not reset to its documented value.");

    chk_setup_write: assert property (@(posedge clk_i) disable iff (rst_i) // R17
        (hit && wb_we_i && wb_adr_i == ASI_SETUP_ADR && wb_sel_i == 4'hf)
        |=> (s.cfg == ($past(wb_dat_i) & ASI_WRITABLE)))
        else $error("Setup register write was not stored.");

    chk_setup_read: assert property (@(posedge clk_i) disable iff (rst_i) // R17
        (hit && !wb_we_i && wb_adr_i == ASI_SETUP_ADR) |=> (wb_ack_o && wb_dat_o == $past(s.cfg)))
        else $error("Setup register read returned wrong data.");

    chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("Bus acknowledge was not a single cycle.");

    chk_mode_write: assert property (@(posedge clk_i) disable iff (rst_i) // R16
        (hit && wb_we_i && wb_adr_i == ASI_SETUP_ADR && wb_sel_i[0]) |=> (mode_ac97_o == $past(wb_dat_i[ASI_MODE])))
        else $error("Mode bit did not follow the write.");

    chk_rx_word_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        (s.ts2 != s.ts3) |=> s.valid ##0 (s.rxd == $past(link_word)))
        else $error("Received word was lost or flag not raised.");

    chk_cfg_hold: assert property (@(posedge clk_i) disable iff (rst_i) // R1
        (s.req != s.as2) |=> $stable(s.shcfg))
        else $error("Setup copy changed while the link was taking it.");

endmodule : asi_setup

// file: tb/asi_codec_model.sv
// Behavioural audio codec that clocks frames into and out of the serial pins.
`timescale 1ns/1ps

module asi_codec_model (
    input  wire logic tx_data_i,
    output logic      bclk_o,
    output logic      fs_o,
    output logic      data_o
);
    localparam int Q = 20;
    logic [63:0] cap;
    initial
    begin
        bclk_o = 1'b0;
        fs_o = 1'b0;
        data_o = 1'b0;
        cap = 64'h0;
    end
    // Parks the bit clock at its idle level; it stands still between frames.
    task automatic park(input logic fall);
        bclk_o = fall;
    endtask : park
    // One bit period; data and sync change a quarter period away from both edges.
    task automatic bit_time(input logic f, input logic d);
        fs_o = f;
        data_o = d;
        #Q;
        cap = {cap[62:0], tx_data_i};
        bclk_o = ~bclk_o;
        #(2 * Q);
        bclk_o = ~bclk_o;
        #Q;
    endtask : bit_time
    // Sends len bits per channel, first bit first; a stereo frame adds a half with sync inactive.
    task automatic frame(input logic [31:0] w0, input logic [31:0] w1, input int len, input logic inv,
                         input logic st);
        bit_time(inv, ~data_o);
        for (int h = 0; h <= int'(st); h++)
            for (int i = len - 1; i >= 0; i--)
                bit_time(inv ^ (h == 0), h ? w1[i] : w0[i]);
        bit_time(inv, ~data_o);
        data_o = ~data_o;
    endtask : frame
endmodule : asi_codec_model

// file: tb/test_asi_setup.sv
// Self-checking bench for the audio serial interface setup block.
`timescale 1ns/1ps

module test_asi_setup;
    import asi_pkg::*;
    logic        clk_i = 1'b0;
    logic        lclk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0;
    logic [3:0]  wb_sel = 4'hf;
    logic        wb_we = 1'b0;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [1:0]  tx_width_o;
    logic [1:0]  rx_width_o;
    logic [5:0]  tx_bits_o;
    logic [5:0]  rx_bits_o;
    logic        mode_ac97_o;
    logic        tx_data_o;
    logic        bclk;
    logic        fs;
    logic        sdata;
    logic [31:0] cfg = 32'h0;
    logic [31:0] seed = 32'hc85783f0;
    logic [31:0] q;
    logic [31:0] d;
    logic [31:0] w0;
    logic [31:0] w1;
    logic [31:0] msk;
    logic [7:0]  m;
    logic [7:0]  modes [7] = '{8'h20, 8'h0e, 8'h48, 8'h14, 8'h21, 8'ha0, 8'ha1};
    int          len;
    int          err_count = 0;
    int          checked = 0;

    always #12.5 clk_i = ~clk_i;
    always #3 lclk_i = ~lclk_i;

    asi_setup asi_setup_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel),
        .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .tx_width_o(tx_width_o), .rx_width_o(rx_width_o), .tx_bits_o(tx_bits_o), .rx_bits_o(rx_bits_o),
        .mode_ac97_o(mode_ac97_o), .lclk_i(lclk_i), .tx_bclk_i(bclk), .rx_bclk_i(cfg[12] & bclk),
        .tx_fs_i(fs), .rx_fs_i(fs ^ cfg[13]), .rx_data_i(sdata), .tx_data_o(tx_data_o)
    );

    asi_codec_model asi_codec_model_i (
        .tx_data_i(tx_data_o), .bclk_o(bclk), .fs_o(fs), .data_o(sdata)
    );

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : rnd

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Classic single cycle; the request is held until ack is sampled high.
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] dv);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= dv;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                check(32'h0, 32'h1);
                tally_and_finish();
            end
            @(posedge clk_i);
        end
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : wb

    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, ASI_SETUP_ADR, 32'h0);
        check(q, ASI_SETUP_RST);
        check({28'h0, tx_width_o, rx_width_o}, 32'ha);
        for (int k = 0; k < 4; k++)
        begin
            d = rnd();
            d[31:30] = 2'(k);
            d[23:22] = 2'(3 - k);
            wb(1, ASI_SETUP_ADR, d);
            wb(0, ASI_SETUP_ADR, 32'h0);
            check(q, d & ASI_WRITABLE);
            check(32'({tx_width_o, rx_width_o, tx_bits_o, rx_bits_o, mode_ac97_o}),
                  32'({d[31:30], d[23:22], d[21:16], d[29:24], d[0]}));
        end
        wb(1, 8'h40, 32'hffffffff);
        wb(0, 8'h40, 32'h0);
        check(q, 32'h0);
        wb_sel <= 4'h8;
        wb(1, ASI_SETUP_ADR, 32'h0);
        wb_sel <= 4'hf;
        wb(0, ASI_SETUP_ADR, 32'h0);
        check(q, {8'h00, d[23:0] & ASI_WRITABLE[23:0]});
        for (int r = 0; r < 2; r++)
            foreach (modes[k])
            begin
                m = modes[k];
                len = m[0] ? 20 : 1 + int'(rnd() % 32);
                msk = 32'((64'h1 << len) - 64'h1);
                w0 = rnd();
                w1 = rnd();
                d = rnd();
                cfg = {2'h2, 6'(m[0] ? 20 + int'(rnd() % 12) : len), 2'h2, 6'(m[0] ? 31 : len),
                       m[7], m[4], m[6], m[5], m[3], m[3], m[1], m[2], 7'h0, m[0]};
                asi_codec_model_i.park(m[1]);
                wb(1, ASI_TXWORD_ADR, d);
                wb(1, ASI_SETUP_ADR, cfg);
                repeat (10) @(posedge clk_i);
                asi_codec_model_i.frame(w0, w1, len, m[3], m[7]);
                check(32'(asi_codec_model_i.cap >> (m[7] ? len : 0)) & msk, d & msk);
                q = 32'h0;
                for (int n = 0; n < 20 && q[ASI_ST_VALID] !== 1'b1; n++)
                    wb(0, ASI_STATUS_ADR, 32'h0);
                check(32'(q[ASI_ST_VALID]), 32'h1);
                if (m[7] & ~m[0])
                    check(32'(q[ASI_ST_CHAN]), 32'h1);
                wb(0, ASI_RXWORD_ADR, 32'h0);
                check(q, (m[4] ? d : (m[7] & ~m[0]) ? w1 : w0) & msk);
            end
        tally_and_finish();
    end
endmodule : test_asi_setup
